// ### core/or_move_literal_ops.sv
// decode and execute of or-into-file, copy-file and literal-load
module or_move_literal_ops
    import or_move_literal_pkg::*;
(
    // clock and reset
    input  wire logic                   CLOCK_IN,
    input  wire logic                   NRST_IN,
    // instruction from fetch, valid for one instruction cycle
    input  wire logic                   INSTR_VALID_IN,
    input  wire logic [INSTR_WIDTH-1:0] INSTR_IN,
    // file register read data for the addressed register
    input  wire logic [DATA_WIDTH-1:0]  FILE_RDATA_IN,
    // file register access
    output logic      [ADDR_WIDTH-1:0]  FILE_ADDR_OUT,
    output logic                        FILE_WE_OUT,
    output logic      [DATA_WIDTH-1:0]  FILE_WDATA_OUT,
    // core state
    output logic      [DATA_WIDTH-1:0]  ACC_OUT,
    output logic                        ZERO_FLAG_OUT,
    output logic                        DONE_OUT
);

    // decode is also used by the checks, so kept as a function
    function automatic op_type decode_op(
        input logic [INSTR_WIDTH-1:0] ins
    );
        op_type op;
        op = OP_NONE;
        if (ins[13:8] == OPC_OR_FILE) begin
            op = OP_OR;
        end else if (ins[13:8] == OPC_COPY_FILE) begin
            op = OP_COPY;
        end else if (ins[13:12] == OPC_LIT_PREFIX &&
                     ins[11:10] == OPC_LIT_SUB) begin
            op = OP_LITERAL; // bits 9:8 not looked at
        end
        return op;
    endfunction

    op_type                  op;
    logic                    dir;
    logic [DATA_WIDTH-1:0]   result;
    logic [DATA_WIDTH-1:0]   acc_q, acc_d;
    logic                    zero_q, zero_d;
    logic                    we_q, we_d;
    logic [DATA_WIDTH-1:0]   wdata_q, wdata_d;
    logic [ADDR_WIDTH-1:0]   addr_q, addr_d;
    logic                    done_q, done_d;

    // file address is combinational from the instruction so the read
    // data returns in the same cycle; registered copy goes with write
    assign op  = INSTR_VALID_IN ? decode_op(INSTR_IN) : OP_NONE;
    assign dir = INSTR_IN[DIR_BIT];

    // next-state: whole instruction resolves in this cycle, no stall
    always_comb begin
        acc_d   = acc_q;
        zero_d  = zero_q;
        we_d    = 1'b0;
        wdata_d = wdata_q;
        addr_d  = addr_q;
        done_d  = 1'b0;
        result  = FILE_RDATA_IN;
        case (op)
            OP_OR: begin
                result = acc_q | FILE_RDATA_IN;
                zero_d = (result == 8'h00);
            end
            OP_COPY: begin
                result = FILE_RDATA_IN;
                zero_d = (result == 8'h00);
            end
            OP_LITERAL: begin
                result = INSTR_IN[7:0];
                acc_d  = INSTR_IN[7:0];
            end
            default: begin
                result = FILE_RDATA_IN;
            end
        endcase
        if (op == OP_OR || op == OP_COPY) begin
            done_d = 1'b1;
            addr_d = INSTR_IN[ADDR_WIDTH-1:0];
            if (!dir) begin
                acc_d = result;
            end else begin
                we_d    = 1'b1;
                wdata_d = result;
            end
        end else if (op == OP_LITERAL) begin
            done_d = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            acc_q   <= ACC_RESET;
            zero_q  <= ZERO_RESET;
            we_q    <= 1'b0;
            wdata_q <= 8'h00;
            addr_q  <= 7'h00;
            done_q  <= 1'b0;
        end else begin
            acc_q   <= acc_d;
            zero_q  <= zero_d;
            we_q    <= we_d;
            wdata_q <= wdata_d;
            addr_q  <= addr_d;
            done_q  <= done_d;
        end
    end

    // read address must be live for same-cycle read; write lags by one
    assign FILE_ADDR_OUT  = we_q ? addr_q : INSTR_IN[ADDR_WIDTH-1:0];
    assign FILE_WE_OUT    = we_q;
    assign FILE_WDATA_OUT = wdata_q;
    assign ACC_OUT        = acc_q;
    assign ZERO_FLAG_OUT  = zero_q;
    assign DONE_OUT       = done_q;

    // checks, all on the one instruction clock
    // reset masks them only while NRST_IN is low; the first edge after release is judged
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!NRST_IN);

    // or into the accumulator
    chk_or_to_acc: assert property (
        (op == OP_OR && !dir) |=> acc_q == $past(acc_q | FILE_RDATA_IN))
        else $error("or result not in accumulator");

    // or back into the file register, accumulator kept
    chk_or_to_file: assert property (
        (op == OP_OR && dir) |=> FILE_WE_OUT &&
            FILE_WDATA_OUT == $past(acc_q | FILE_RDATA_IN) &&
            $stable(acc_q))
        else $error("or writeback wrong");

    // zero flag follows the or result for either destination
    chk_or_zero: assert property (
        (op == OP_OR) |=> zero_q == ($past(acc_q | FILE_RDATA_IN) == 8'h00))
        else $error("or zero flag wrong");

    // copy into the accumulator
    chk_copy_acc: assert property (
        (op == OP_COPY && !dir) |=> acc_q == $past(FILE_RDATA_IN))
        else $error("copy value not in accumulator");

    // copy back to the same register, value unchanged
    chk_copy_back: assert property (
        (op == OP_COPY && dir) |=> FILE_WE_OUT &&
            FILE_WDATA_OUT == $past(FILE_RDATA_IN) && $stable(acc_q))
        else $error("copy writeback wrong");

    // copy writeback must land on the register that was read
    chk_write_addr: assert property (
        (op == OP_COPY && dir) |=>
            FILE_ADDR_OUT == $past(INSTR_IN[ADDR_WIDTH-1:0]))
        else $error("writeback address wrong");

    // zero test by copying a register onto itself
    chk_copy_zero: assert property (
        (op == OP_COPY) |=> zero_q == ($past(FILE_RDATA_IN) == 8'h00))
        else $error("copy zero flag wrong");

    // literal goes to the accumulator, flags and file left alone
    chk_lit_load: assert property (
        (op == OP_LITERAL) |=> acc_q == $past(INSTR_IN[7:0]) &&
            $stable(zero_q) && !FILE_WE_OUT)
        else $error("literal load wrong");

    // both don't-care bits of the literal prefix decode the same
    chk_lit_dontcare: assert property (
        (INSTR_VALID_IN && INSTR_IN[13:10] == 4'hC) |-> op == OP_LITERAL)
        else $error("literal don't care bits decoded");

    // done pulse exactly one cycle after each decoded instruction
    chk_single_cycle: assert property (
        (op != OP_NONE) |=> DONE_OUT ##1 (DONE_OUT == $past(op != OP_NONE)))
        else $error("instruction not done in one cycle");

    // an idle or unknown word leaves all state alone
    chk_idle_quiet: assert property (
        (op == OP_NONE) |=> !DONE_OUT && !FILE_WE_OUT &&
            $stable(acc_q) && $stable(zero_q))
        else $error("idle cycle changed state");

    // main scenarios seen at least once
    cov_or_file: cover property ((op == OP_OR && dir) ##1 FILE_WE_OUT);
    cov_copy_zero: cover property ((op == OP_COPY && dir) ##1 zero_q);
    cov_lit: cover property ((op == OP_LITERAL) ##1 (op == OP_OR));
    cov_refused: cover property (
        (INSTR_VALID_IN && op == OP_NONE) ##1 !DONE_OUT);
endmodule

// ### inc/or_move_literal_pkg.sv
// constants for the or/copy/literal instruction block
package or_move_literal_pkg;
    localparam int          INSTR_WIDTH     = 14;
    localparam int          DATA_WIDTH      = 8;
    localparam int          ADDR_WIDTH      = 7;
    // opcode fields
    localparam logic [5:0]  OPC_OR_FILE     = 6'h04;
    localparam logic [5:0]  OPC_COPY_FILE   = 6'h08;
    localparam logic [1:0]  OPC_LIT_PREFIX  = 2'h3;
    localparam logic [1:0]  OPC_LIT_SUB     = 2'h0;
    // field positions
    localparam int          DIR_BIT         = 7;
    // reset values
    localparam logic [7:0]  ACC_RESET       = 8'h00;
    localparam logic        ZERO_RESET      = 1'b0;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_OR,
        OP_COPY,
        OP_LITERAL
    } op_type;
endpackage

// ### verif/tb_top.sv
// self-checking bench for the or/copy/literal block
module tb_top
    import or_move_literal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        vld = 1'b0;
    logic [13:0] ins = 14'h0000;
    logic [7:0]  rdata, wdata, acc;
    logic [7:0]  mem [128];
    logic [6:0]  addr;
    logic        we, zf, done;
    int          errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    always #5 clk = ~clk;
    // file model answers whatever address the block shows
    assign rdata = mem[addr];
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        cycles <= cycles + 1;
        // ceiling well above the few dozen cycles the tests need
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end
    or_move_literal_ops dut (.CLOCK_IN(clk), .NRST_IN(nrst),
        .INSTR_VALID_IN(vld), .INSTR_IN(ins), .FILE_RDATA_IN(rdata),
        .FILE_ADDR_OUT(addr), .FILE_WE_OUT(we), .FILE_WDATA_OUT(wdata),
        .ACC_OUT(acc), .ZERO_FLAG_OUT(zf), .DONE_OUT(done));
    task chk(input string what, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one instruction, results looked at one cycle after it is taken
    task exec(input logic [13:0] i);
        @(posedge clk);
        vld <= 1'b1;
        ins <= i;
        @(posedge clk);
        vld <= 1'b0;
        #1;
        chk("done", {7'h00, done}, 8'h01);
    endtask
    task test_or;
        mem[5] = 8'h13;
        exec({OPC_LIT_PREFIX, OPC_LIT_SUB, 2'h0, 8'h91});
        exec({OPC_OR_FILE, 1'b0, 7'h05});
        chk("acc", acc, 8'h93);
        chk("we", {7'h00, we}, 8'h00);
        chk("zero", {7'h00, zf}, 8'h00);
        exec({OPC_OR_FILE, 1'b1, 7'h05});
        chk("wdata", wdata, 8'h93);
        chk("we", {7'h00, we}, 8'h01);
        $display("test_or finished");
    endtask
    task test_copy;
        mem[9] = 8'h00;
        mem[10] = 8'h5a;
        exec({OPC_COPY_FILE, 1'b0, 7'h09});
        chk("acc", acc, 8'h00);
        chk("zero", {7'h00, zf}, 8'h01);
        exec({OPC_COPY_FILE, 1'b1, 7'h0a});
        chk("we", {7'h00, we}, 8'h01);
        chk("wdata", wdata, 8'h5a);
        chk("addr", {1'b0, addr}, 8'h0a);
        chk("acc kept", acc, 8'h00);
        chk("zero", {7'h00, zf}, 8'h00);
        exec({OPC_COPY_FILE, 1'b1, 7'h09});
        chk("zero", {7'h00, zf}, 8'h01);
        $display("test_copy finished");
    endtask
    // don't-care bits 9:8 given as 3 and 1; zero flag must not follow
    task test_literal;
        exec({OPC_LIT_PREFIX, OPC_LIT_SUB, 2'h3, 8'ha5});
        chk("acc", acc, 8'ha5);
        chk("zero", {7'h00, zf}, 8'h01);
        exec({OPC_COPY_FILE, 1'b1, 7'h0a});
        exec({OPC_LIT_PREFIX, OPC_LIT_SUB, 2'h1, 8'h00});
        chk("acc", acc, 8'h00);
        chk("zero", {7'h00, zf}, 8'h00);
        $display("test_literal finished");
    endtask
    // unknown words are dropped with no done, no write, no change
    task test_refused;
        exec({OPC_LIT_PREFIX, OPC_LIT_SUB, 2'h0, 8'h3c});
        @(posedge clk);
        vld <= 1'b1;
        ins <= 14'h3455;
        @(posedge clk);
        vld <= 1'b0;
        #1;
        chk("done", {7'h00, done}, 8'h00);
        chk("we", {7'h00, we}, 8'h00);
        chk("acc", acc, 8'h3c);
        $display("test_refused finished");
    endtask
    // reset in mid-run clears accumulator and zero flag
    task test_reset;
        exec({OPC_COPY_FILE, 1'b0, 7'h09});
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("acc reset", acc, ACC_RESET);
        chk("zero reset", {7'h00, zf}, {7'h00, ZERO_RESET});
        exec({OPC_LIT_PREFIX, OPC_LIT_SUB, 2'h0, 8'h7e});
        chk("acc", acc, 8'h7e);
        $display("test_reset finished");
    endtask
    task summarize;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        foreach (mem[k]) mem[k] = 8'h00;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("acc reset", acc, ACC_RESET);
        test_or();
        test_copy();
        test_literal();
        test_refused();
        test_reset();
        summarize();
    end
endmodule
